/* File: mgmt_pkg.sv */
/*
  Shared constants and types for the optical module control and status block.
  Assumes a 10 MHz core clock; all pin inputs arrive from outside that domain.
*/
`default_nettype none
package mgmt_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned T_INIT_MS = 2000;
  localparam int unsigned INIT_CYC = T_INIT_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_W = 25;
  localparam int unsigned T_RESET_MIN_US = 2;
  localparam int unsigned RESET_MIN_CYC = (T_RESET_MIN_US * CLK_HZ + 999_999) / 1_000_000;
  localparam logic [7:0] RESET_MIN = RESET_MIN_CYC[7:0];

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h00;
  localparam logic [AW-1:0] ADDR_FLAGS = 8'h01;
  localparam logic [AW-1:0] ADDR_MASK = 8'h02;
  localparam logic [AW-1:0] ADDR_CONTROL = 8'h03;
  localparam logic [AW-1:0] ADDR_MODSTATE = 8'h04;

  localparam int unsigned DNR_BIT = 0;
  localparam int unsigned PDOWN_BIT = 0;
  localparam int unsigned NFLAG = 4;
  localparam int unsigned FLAG_LOS = 0;
  localparam int unsigned FLAG_TXF = 1;
  localparam int unsigned FLAG_OTH = 2;
  localparam int unsigned FLAG_INIT = 3;
  localparam int unsigned MS_LOWPWR = 0;
  localparam int unsigned MS_BUSEN = 1;
  localparam int unsigned MS_READY = 2;

  localparam int unsigned NPIN = 8;
  localparam int unsigned PIN_RST_N = 0;
  localparam int unsigned PIN_SEL_N = 1;
  localparam int unsigned PIN_LP = 2;
  localparam int unsigned PIN_SCL = 3;
  localparam int unsigned PIN_SDA = 4;
  localparam int unsigned PIN_LOS = 5;
  localparam int unsigned PIN_TXF = 6;
  localparam int unsigned PIN_OTH = 7;
  localparam logic [NPIN-1:0] PIN_RST_VAL = 8'h1B;
  localparam logic [NFLAG-1:0] MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_HELD = 3'b001,
    ST_INIT = 3'b010,
    ST_RUN = 3'b100
  } mode_t;

  typedef struct packed {
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] filt;
    mode_t mode;
    logic [INIT_W-1:0] init_cnt;
    logic [7:0] low_cnt;
    logic stop_seen;
    logic dnr;
    logic [NFLAG-1:0] flags;
    logic [NFLAG-1:0] pend_clr;
    logic [NFLAG-1:0] mask_sh;
    logic [NFLAG-1:0] mask;
    logic pdown_sh;
    logic pdown;
    logic [DW-1:0] rdata;
    logic int_n;
    logic present_n;
    logic bus_en;
    logic low_power;
  } state_t;
endpackage
`default_nettype wire

/* File: optical_module_mgmt_control.sv */
/*
  Control and status logic of a four-lane pluggable optical module: reset and
  initialization, data-not-ready, latched maskable flags driving the active-low
  interrupt, select gating of management access, low-power entry.
  Assumes: a register port fed by the 2-wire slave engine, one-cycle strobes,
  and all pins (reset, select, low power, SCL, SDA, fault levels) asynchronous.
*/
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module optical_module_mgmt_control
  import mgmt_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic module_reset_n_in,
  input wire logic module_select_n_in,
  input wire logic low_power_select_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic rx_los_in,
  input wire logic tx_fault_in,
  input wire logic other_fault_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rdata_out,
  output logic interrupt_out_n_out,
  output logic module_present_n_out,
  output logic low_power_out,
  output logic bus_enable_out
);
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

  state_t s_reg;
  state_t s_next;
  logic [NPIN-1:0] pins;
  logic scl_fall;
  logic sda_rise;
  logic commit;
  logic [NFLAG-1:0] ev;
  logic [NFLAG-1:0] clr;
  logic [DW-1:0] rmux;

  always_comb begin
    pins = '0;
    pins[PIN_RST_N] = module_reset_n_in;
    pins[PIN_SEL_N] = module_select_n_in;
    pins[PIN_LP] = low_power_select_in;
    pins[PIN_SCL] = scl_in;
    pins[PIN_SDA] = sda_in;
    pins[PIN_LOS] = rx_los_in;
    pins[PIN_TXF] = tx_fault_in;
    pins[PIN_OTH] = other_fault_in;
  end

  always_comb begin
    s_next = s_reg;
    ev = '0;
    clr = '0;
    rmux = '0;
    // three-stage sampling; a level counts once stages two and three agree
    s_next.sync1 = pins;
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    s_next.filt = (s_reg.sync2 & s_reg.sync3) | (s_reg.filt & (s_reg.sync2 | s_reg.sync3));

    // stop condition, then the next SCL fall is the reference instant
    sda_rise = s_next.filt[PIN_SDA] & ~s_reg.filt[PIN_SDA];
    scl_fall = s_reg.filt[PIN_SCL] & ~s_next.filt[PIN_SCL];
    commit = s_reg.stop_seen & scl_fall;
    if (s_next.filt[PIN_SCL] & sda_rise) begin
      s_next.stop_seen = 1'b1;
    end else if (commit) begin
      s_next.stop_seen = 1'b0;
    end

    // short low glitches are not a reset
    if (s_next.filt[PIN_RST_N]) begin
      s_next.low_cnt = '0;
    end else if (s_reg.low_cnt != RESET_MIN) begin
      s_next.low_cnt = s_reg.low_cnt + 8'h01;
    end

    s_next.present_n = 1'b0;
    s_next.low_power = s_next.filt[PIN_LP] | s_reg.pdown;
    s_next.rdata = '0;

    case (s_reg.mode)
      ST_HELD: begin
        if (s_next.filt[PIN_RST_N]) begin
          s_next.mode = ST_INIT;
          s_next.init_cnt = '0;
        end
      end
      ST_INIT: begin
        if (s_reg.init_cnt == INIT_LAST) begin
          s_next.mode = ST_RUN;
          s_next.dnr = 1'b0;
          ev[FLAG_INIT] = 1'b1;
        end else begin
          s_next.init_cnt = s_reg.init_cnt + INIT_W'(1);
        end
      end
      ST_RUN: begin
        ev[FLAG_LOS] = s_reg.filt[PIN_LOS];
        ev[FLAG_TXF] = s_reg.filt[PIN_TXF];
        ev[FLAG_OTH] = s_reg.filt[PIN_OTH];
      end
      default: begin
        s_next.mode = ST_HELD;
      end
    endcase

    // clear-on-read takes effect at the reference instant; a new event wins
    if (commit) begin
      clr = s_reg.pend_clr;
      s_next.pend_clr = '0;
      s_next.mask = s_reg.mask_sh;
      s_next.pdown = s_reg.pdown_sh;
    end
    s_next.flags = (s_reg.flags & ~clr) | ev;

    case (addr_in)
      ADDR_STATUS: rmux[DNR_BIT] = s_reg.dnr;
      ADDR_FLAGS: rmux[NFLAG-1:0] = s_reg.flags;
      ADDR_MASK: rmux[NFLAG-1:0] = s_reg.mask_sh;
      ADDR_CONTROL: rmux[PDOWN_BIT] = s_reg.pdown_sh;
      ADDR_MODSTATE: begin
        rmux[MS_LOWPWR] = s_reg.low_power;
        rmux[MS_BUSEN] = s_reg.bus_en;
        rmux[MS_READY] = ~s_reg.dnr;
      end
      default: rmux = '0;
    endcase

    // access only while selected and ready; otherwise reads give zero
    if (s_reg.bus_en) begin
      if (rd_in) begin
        s_next.rdata = rmux;
        if (addr_in == ADDR_FLAGS) begin
          s_next.pend_clr = s_next.pend_clr | s_reg.flags;
        end
      end
      if (wr_in) begin
        if (addr_in == ADDR_MASK) begin
          s_next.mask_sh = wdata_in[NFLAG-1:0];
        end
        if (addr_in == ADDR_CONTROL) begin
          s_next.pdown_sh = wdata_in[PDOWN_BIT];
        end
      end
    end
    s_next.bus_en = (s_next.mode == ST_RUN) & ~s_next.filt[PIN_SEL_N];

    // unmasked latched flags pull the interrupt low
    s_next.int_n = ~|(s_reg.flags & ~s_reg.mask);

    // a reset pulse longer than the minimum sends the mode to ST_HELD and clears flags, masks and controls; samplers run on
    if (s_reg.low_cnt == RESET_MIN) begin
      s_next.mode = ST_HELD;
      s_next.init_cnt = '0;
      s_next.stop_seen = 1'b0;
      s_next.dnr = 1'b1;
      s_next.flags = '0;
      s_next.pend_clr = '0;
      s_next.mask_sh = MASK_RST;
      s_next.mask = MASK_RST;
      s_next.pdown_sh = 1'b0;
      s_next.pdown = 1'b0;
      s_next.rdata = '0;
      s_next.int_n = 1'b1;
      s_next.bus_en = 1'b0;
      s_next.low_power = s_next.filt[PIN_LP];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg.sync1 <= PIN_RST_VAL;
      s_reg.sync2 <= PIN_RST_VAL;
      s_reg.sync3 <= PIN_RST_VAL;
      s_reg.filt <= PIN_RST_VAL;
      s_reg.mode <= ST_INIT;
      s_reg.init_cnt <= '0;
      s_reg.low_cnt <= '0;
      s_reg.stop_seen <= 1'b0;
      s_reg.dnr <= 1'b1;
      s_reg.flags <= '0;
      s_reg.pend_clr <= '0;
      s_reg.mask_sh <= MASK_RST;
      s_reg.mask <= MASK_RST;
      s_reg.pdown_sh <= 1'b0;
      s_reg.pdown <= 1'b0;
      s_reg.rdata <= '0;
      s_reg.int_n <= 1'b1;
      s_reg.present_n <= 1'b0;
      s_reg.bus_en <= 1'b0;
      s_reg.low_power <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign interrupt_out_n_out = s_reg.int_n;
  assign module_present_n_out = s_reg.present_n;
  assign low_power_out = s_reg.low_power;
  assign bus_enable_out = s_reg.bus_en;
endmodule
`default_nettype wire

/* File: omc_checker.sv */
/* Assertions for the module control block.
   Assumes it is bound to the block and the bench keeps select low through init. */
`timescale 1ns/1ps
`default_nettype none
module omc_checker
  import mgmt_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic module_reset_n_in,
  input wire logic module_select_n_in,
  input wire logic low_power_select_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic rd_in,
  input wire logic [DW-1:0] rdata_out,
  input wire logic interrupt_out_n_out,
  input wire logic module_present_n_out,
  input wire logic low_power_out,
  input wire logic bus_enable_out
);
  localparam int unsigned T_EN = INIT_CYCLES + 10;
  logic [15:0] up_reg;
  logic [5:0] low_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      up_reg <= 16'h0000;
    end else if (up_reg != 16'hFFFF) begin
      up_reg <= up_reg + 16'h0001;
    end
  end
  // raw low time of the reset pin, saturating
  always_ff @(posedge clk_in) begin
    if (rst_in || module_reset_n_in) begin
      low_reg <= 6'h00;
    end else if (low_reg != 6'h3F) begin
      low_reg <= low_reg + 6'h01;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_present; module_present_n_out == 1'b0; endproperty
  a_present: assert property (p_present) else $error("presence not low");
  property p_hold; low_reg >= 6'h1E |-> !bus_enable_out && interrupt_out_n_out; endproperty
  a_hold: assert property (p_hold) else $error("reset pin hold ignored");
  property p_lp; $rose(low_power_select_in) |-> ##[1:1000] (low_power_out || !low_power_select_in); endproperty
  a_lp: assert property (p_lp) else $error("low power late");
  property p_desel; $rose(module_select_n_in) |-> ##[1:1000] (!bus_enable_out || !module_select_n_in); endproperty
  a_desel: assert property (p_desel) else $error("deselect late");
  property p_rdy_bus; up_reg == T_EN[15:0] && !module_select_n_in |-> bus_enable_out; endproperty
  a_rdy_bus: assert property (p_rdy_bus) else $error("bus not ready after init");
  property p_rdy_int; up_reg == T_EN[15:0] |-> !interrupt_out_n_out; endproperty
  a_rdy_int: assert property (p_rdy_int) else $error("interrupt not low after init");
  property p_refuse; rd_in && !bus_enable_out |=> rdata_out == 8'h00; endproperty
  a_refuse: assert property (p_refuse) else $error("read answered while disabled");
  property p_status; rd_in && bus_enable_out && addr_in == ADDR_STATUS |=> rdata_out == 8'h00; endproperty
  a_status: assert property (p_status) else $error("not ready seen in run");
  c_rd: cover property (rd_in && bus_enable_out);
  c_lp: cover property (low_power_out);
  c_irq: cover property ($fell(interrupt_out_n_out));
endmodule
bind optical_module_mgmt_control omc_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.clk_in, .rst_in,
  .module_reset_n_in, .module_select_n_in, .low_power_select_in, .addr_in, .rd_in, .rdata_out,
  .interrupt_out_n_out, .module_present_n_out, .low_power_out, .bus_enable_out);
`default_nettype wire

/* File: host_link.sv */
/* Host side of the 2-wire link: one short frame per go pulse.
   Assumes pull-ups, so both lines idle high; the clock stands still between frames. */
`timescale 1ns/1ps
`default_nettype none
module host_link (
  input wire logic go_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  always @(posedge go_in) begin
    sda_out = 1'b0;
    repeat (2) begin
      #400 scl_out = 1'b0;
      #400 scl_out = 1'b1;
    end
    #400 sda_out = 1'b1;
    #400 scl_out = 1'b0;
    #400 scl_out = 1'b1;
  end
endmodule
`default_nettype wire

/* File: test_optical_module_mgmt_control.sv */
/* Self-checking bench for the module control block.
   Assumes host_link as the link partner and a shortened init count. */
`timescale 1ns/1ps
`default_nettype none
module test_optical_module_mgmt_control;
  import mgmt_pkg::*;
  localparam int unsigned N_INIT = 50;
  logic clk_in = 1'b0, rst_in = 1'b1, module_reset_n_in = 1'b1, module_select_n_in = 1'b0;
  logic low_power_select_in = 1'b0, rx_los_in = 1'b0, tx_fault_in = 1'b0, other_fault_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic wr_in = 1'b0, rd_in = 1'b0, go = 1'b0, scl_in, sda_in;
  logic interrupt_out_n_out, module_present_n_out, low_power_out, bus_enable_out;
  int n_errors = 0, comparisons = 0, seed, b;
  always #50 clk_in = ~clk_in;
  host_link link (.go_in(go), .scl_out(scl_in), .sda_out(sda_in));
  optical_module_mgmt_control #(.INIT_CYCLES(N_INIT)) DUT (.clk_in, .rst_in, .module_reset_n_in,
    .module_select_n_in, .low_power_select_in, .scl_in, .sda_in, .rx_los_in, .tx_fault_in,
    .other_fault_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .interrupt_out_n_out,
    .module_present_n_out, .low_power_out, .bus_enable_out);
  task final_report;
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task check1(input logic s, input logic e);
    check({7'h00, s}, {7'h00, e});
  endtask
  function automatic logic [7:0] flag_bit(input int k);
    flag_bit = 8'h01 << k;
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    cyc(1);
    wr_in <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    cyc(1);
    rd_in <= 1'b0;
    cyc(1);
    check(rdata_out, e);
  endtask
  // changes commit only at the link clock fall after a stop
  task frame;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(50);
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    final_report();
  end
  initial begin
    seed = 32'h400E;
    cyc(3);
    rst_in <= 1'b0;
    cyc(5);
    check1(interrupt_out_n_out, 1'b1);
    rd_reg(ADDR_MASK, 8'h00);
    cyc(N_INIT + 10);
    check1(interrupt_out_n_out, 1'b0);
    check1(bus_enable_out, 1'b1);
    check1(module_present_n_out, 1'b0);
    rd_reg(ADDR_STATUS, 8'h00);
    rd_reg(ADDR_FLAGS, 8'h08);
    rd_reg(8'h07, 8'h00);
    frame();
    check1(interrupt_out_n_out, 1'b1);
    repeat (6) begin
      b = $unsigned($random(seed)) % 3;
      {other_fault_in, tx_fault_in, rx_los_in} <= 3'b001 << b;
      cyc(10);
      check1(interrupt_out_n_out, 1'b0);
      rd_reg(ADDR_FLAGS, flag_bit(b));
      {other_fault_in, tx_fault_in, rx_los_in} <= 3'b000;
      frame();
      check1(interrupt_out_n_out, 1'b1);
    end
    wr_reg(ADDR_MASK, 8'h02);
    frame();
    tx_fault_in <= 1'b1;
    cyc(10);
    check1(interrupt_out_n_out, 1'b1);
    rd_reg(ADDR_MASK, 8'h02);
    wr_reg(ADDR_MASK, 8'h00);
    cyc(10);
    check1(interrupt_out_n_out, 1'b1);
    frame();
    check1(interrupt_out_n_out, 1'b0);
    tx_fault_in <= 1'b0;
    rd_reg(ADDR_FLAGS, 8'h02);
    frame();
    low_power_select_in <= 1'b1;
    cyc(10);
    check1(low_power_out, 1'b1);
    low_power_select_in <= 1'b0;
    wr_reg(ADDR_CONTROL, 8'h01);
    cyc(10);
    check1(low_power_out, 1'b0);
    frame();
    check1(low_power_out, 1'b1);
    rd_reg(ADDR_CONTROL, 8'h01);
    rd_reg(ADDR_MODSTATE, 8'h07);
    wr_reg(ADDR_CONTROL, 8'h00);
    frame();
    check1(low_power_out, 1'b0);
    module_select_n_in <= 1'b1;
    cyc(10);
    check1(bus_enable_out, 1'b0);
    rd_reg(ADDR_FLAGS, 8'h00);
    module_select_n_in <= 1'b0;
    cyc(10);
    check1(bus_enable_out, 1'b1);
    module_reset_n_in <= 1'b0;
    cyc(5);
    module_reset_n_in <= 1'b1;
    cyc(10);
    check1(bus_enable_out, 1'b1);
    module_reset_n_in <= 1'b0;
    cyc(30);
    check1(bus_enable_out, 1'b0);
    check1(interrupt_out_n_out, 1'b1);
    module_reset_n_in <= 1'b1;
    cyc(N_INIT + 12);
    check1(interrupt_out_n_out, 1'b0);
    check1(bus_enable_out, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
